// [hdl/sfs_pkg.sv]
package sfs_pkg;
   // command opcodes seen on the serial link
   localparam logic [7:0] OP_WRITE_REGISTERS = 8'h01;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
   localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
   localparam logic [7:0] OP_PROGRAM_SUSPEND = 8'h85;
   localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
   localparam logic [7:0] OP_WHOLE_ERASE = 8'h60;
   // status byte field positions
   localparam int BIT_LOCK = 7;
   localparam int BIT_PERR = 6;
   localparam int BIT_EERR = 5;
   localparam int BIT_BP_HI = 4;
   localparam int BIT_BP_LO = 2;
   localparam int BIT_WEL = 1;
   localparam int BIT_BUSY = 0;
   // config bits, the volatile protect reset value and the last bit count
   localparam int CFG_PROTECT_VOLATILITY_BIT = 3;
   localparam int CFG_FREEZE = 0;
   localparam logic [2:0] BP_RESET_VOLATILE = 3'h7;
   localparam logic [2:0] BIT_COUNT_LAST = 3'h7;

   // status register contents
   typedef struct packed {
      logic status_write_lock;
      logic prog_err;
      logic erase_err;
      logic [2:0] protect_bits;
      logic write_enable_latch;
      logic busy_flag;
   } sfs_status_t;

   // events from the program/erase engine
   typedef struct packed {
      logic done_ok;
      logic prog_fail;
      logic erase_fail;
      logic prog_in_progress;
      logic erase_in_progress;
   } sfs_engine_t;

   // one-cycle command strobes toward the engine
   typedef struct packed {
      logic start_program;
      logic start_sector_erase;
      logic start_whole_erase;
      logic erase_suspend;
      logic program_suspend;
      logic soft_reset;
   } sfs_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_OPCODE = 4'h2,
      ST_DATA = 4'h4,
      ST_READOUT = 4'h8
   } sfs_phase_t;
endpackage

// [hdl/sfs_status_reg.sv]
`timescale 1ns/1ps
module sfs_status_reg (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic select_n,
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic write_protect_n,
   input wire logic [7:0] config_register_one,
   input wire logic [2:0] nv_protect_bits,
   input wire logic nv_status_write_lock,
   input wire logic target_protected,
   input wire sfs_pkg::sfs_engine_t engine,
   output logic serial_out,
   output logic serial_out_en,
   output sfs_pkg::sfs_cmd_t cmd,
   output logic [7:0] flash_status_one
);
   typedef struct packed {
      logic [1:0] sel_sync;
      logic [1:0] clk_sync;
      logic [1:0] din_sync;
      logic [1:0] wp_sync;
      logic clk_prev;
      sfs_pkg::sfs_phase_t phase;
      logic [2:0] bit_cnt;
      logic [7:0] shift_in;
      logic [7:0] opcode;
      logic [7:0] shift_out;
      logic dout;
      logic dout_en;
      sfs_pkg::sfs_status_t status;
      sfs_pkg::sfs_cmd_t cmd;
   } sfs_state_t;

   // how a frame travels through this block:
   // - select low moves the phase from idle to opcode collection
   // - every link clock rise outside readout shifts one data bit in, msb first
   // - the eighth bit completes the opcode and the command is judged
   //   against busy, the write-enable latch and the protection state
   // - the OP_READ_STATUS opcode (not OP_READ_STATUS_TWO) switches to readout, where falling link
   //   edges move the status byte out and it reloads every eight bits
   // - any other opcode moves to the data phase; only a write-registers
   //   opcode that passed its checks may use the byte that follows
   // - select high drops whatever is unfinished and returns to idle
   // the link pins are sampled by the core clock, so the link clock must
   // stay well below a quarter of the core clock for edges to be seen
   sfs_state_t state;
   sfs_state_t next_state;

   // opcodes that a busy device still honours; every other opcode is
   // dropped without trace, which keeps a running operation safe from a
   // stray command sent by a confused host
   function automatic logic sfs_busy_allowed(input logic [7:0] op);
      case (op)
         sfs_pkg::OP_READ_STATUS, sfs_pkg::OP_READ_STATUS_TWO: begin
            sfs_busy_allowed = 1'b1; // polling must always work
         end
         sfs_pkg::OP_ERASE_SUSPEND, sfs_pkg::OP_PROGRAM_SUSPEND: begin
            sfs_busy_allowed = 1'b1; // the engine state decides later
         end
         sfs_pkg::OP_CLEAR_STATUS, sfs_pkg::OP_SOFT_RESET: begin
            sfs_busy_allowed = 1'b1; // the only ways out of an error
         end
         default: begin
            sfs_busy_allowed = 1'b0;
         end
      endcase
   endfunction

   // status struct to the byte seen by the host; the struct order
   // already matches the byte, so this is a plain repacking, kept as a
   // function so the readout and the output port cannot drift apart
   function automatic logic [7:0] sfs_pack(input sfs_pkg::sfs_status_t s);
      sfs_pack = s;
   endfunction

   logic selected;
   logic sclk_rise;
   logic sclk_fall;
   logic byte_done;
   logic [7:0] byte_val;
   logic hw_protected;
   logic frozen;

   // decode of synchronised link pins; first stage is never read here
   // edges come from comparing the second sync stage with its own
   // previous value, so a glitch shorter than a core cycle may be lost;
   // the data bit is taken from the same stage as the clock, so both
   // see the same delay and the bit is stable when the edge is found
   // the freeze bit is a level from logic on this clock and needs no sync
   always_comb begin
      selected = !state.sel_sync[1];
      sclk_rise = state.clk_sync[1] && !state.clk_prev;
      sclk_fall = !state.clk_sync[1] && state.clk_prev;
      byte_val = {state.shift_in[6:0], state.din_sync[1]};
      byte_done = selected && sclk_rise && (state.bit_cnt == sfs_pkg::BIT_COUNT_LAST);
      hw_protected = state.status.status_write_lock && !state.wp_sync[1];
      frozen = config_register_one[sfs_pkg::CFG_FREEZE];
   end

   always_comb begin
      next_state = state;
      next_state.sel_sync = {state.sel_sync[0], select_n};
      next_state.clk_sync = {state.clk_sync[0], serial_clk};
      next_state.din_sync = {state.din_sync[0], serial_in};
      next_state.wp_sync = {state.wp_sync[0], write_protect_n};
      next_state.clk_prev = state.clk_sync[1];
      next_state.cmd = '0;

      // engine events; error flags hold busy until cleared
      // an error also forces busy, so a flag is never seen high while
      // the device claims to be idle and ready for new work
      if (engine.prog_fail) begin
         next_state.status.prog_err = 1'b1;
         next_state.status.busy_flag = 1'b1;
      end
      if (engine.erase_fail) begin
         next_state.status.erase_err = 1'b1;
         next_state.status.busy_flag = 1'b1;
      end
      // a normal end of operation releases busy and the latch; with an
      // error pending the device must stay busy until clear-status or soft reset
      if (engine.done_ok && !state.status.prog_err && !state.status.erase_err &&
          !engine.prog_fail && !engine.erase_fail) begin
         next_state.status.busy_flag = 1'b0;
         next_state.status.write_enable_latch = 1'b0;
      end

      // link framing
      // deselect aborts any partial byte and stops driving the output;
      // the bit counter restarts so the next frame begins on a clean byte
      if (!selected) begin
         next_state.phase = sfs_pkg::ST_IDLE;
         next_state.bit_cnt = '0;
         next_state.dout_en = 1'b0;
      end else begin
         if (state.phase == sfs_pkg::ST_IDLE) begin
            next_state.phase = sfs_pkg::ST_OPCODE;
         end
         if (sclk_rise && state.phase != sfs_pkg::ST_READOUT) begin
            next_state.shift_in = byte_val;
            next_state.bit_cnt = state.bit_cnt + 3'h1;
         end
         // status byte leaves msb first on falling edges, wrapping
         // the reload takes the freshly computed status, so a busy flag
         // that drops during a long poll shows in the very next byte;
         // the last fall of a frame shifts once more, which is harmless
         // because the host has already taken its final bit
         if (state.phase == sfs_pkg::ST_READOUT && sclk_fall) begin
            next_state.dout = state.shift_out[7];
            next_state.dout_en = 1'b1;
            if (state.bit_cnt == sfs_pkg::BIT_COUNT_LAST) begin
               next_state.shift_out = sfs_pack(next_state.status);
            end else begin
               next_state.shift_out = {state.shift_out[6:0], 1'b0};
            end
            next_state.bit_cnt = state.bit_cnt + 3'h1;
         end
      end

      // opcode byte complete
      // after the opcode the frame never returns to opcode collection:
      // a trailing byte of a refused command must not be taken as a
      // second opcode, or a refused write could carry a hidden command
      // opcode is kept only for an accepted write-registers command and
      // is otherwise emptied, so the data phase knows what it may do
      if (byte_done && state.phase == sfs_pkg::ST_OPCODE) begin
         next_state.opcode = '0;
         next_state.bit_cnt = '0;
         next_state.phase = sfs_pkg::ST_DATA;
         if (!state.status.busy_flag || sfs_busy_allowed(byte_val)) begin
            case (byte_val)
               sfs_pkg::OP_READ_STATUS: begin
                  next_state.phase = sfs_pkg::ST_READOUT;
                  next_state.shift_out = sfs_pack(state.status);
               end
               sfs_pkg::OP_WRITE_ENABLE: begin
                  next_state.status.write_enable_latch = 1'b1;
               end
               sfs_pkg::OP_WRITE_DISABLE: begin
                  next_state.status.write_enable_latch = 1'b0;
               end
               sfs_pkg::OP_CLEAR_STATUS: begin
                  // clear loses to an error landing this cycle, and so
                  // does the release of busy, or a fresh error would sit
                  // in the byte while the device looks idle
                  next_state.status.prog_err = engine.prog_fail;
                  next_state.status.erase_err = engine.erase_fail;
                  if ((state.status.prog_err || state.status.erase_err) &&
                      !engine.prog_fail && !engine.erase_fail) begin
                     next_state.status.busy_flag = 1'b0;
                  end
               end
               sfs_pkg::OP_ERASE_SUSPEND: begin
                  next_state.cmd.erase_suspend = engine.erase_in_progress;
               end
               sfs_pkg::OP_PROGRAM_SUSPEND: begin
                  next_state.cmd.program_suspend = engine.prog_in_progress;
               end
               sfs_pkg::OP_SOFT_RESET: begin
                  next_state.cmd.soft_reset = 1'b1;
                  next_state.status.write_enable_latch = 1'b0;
                  next_state.status.busy_flag = 1'b0;
                  next_state.status.prog_err = 1'b0;
                  next_state.status.erase_err = 1'b0;
                  if (config_register_one[sfs_pkg::CFG_PROTECT_VOLATILITY_BIT]) begin
                     next_state.status.protect_bits = sfs_pkg::BP_RESET_VOLATILE;
                  end
               end
               sfs_pkg::OP_WRITE_REGISTERS: begin
                  // data byte follows; the checks are made here, at the opcode
                  if (state.status.write_enable_latch && !hw_protected) begin
                     next_state.opcode = byte_val;
                  end
               end
               sfs_pkg::OP_PROGRAM: begin
                  if (state.status.write_enable_latch) begin
                     next_state.status.busy_flag = 1'b1;
                     if (target_protected) begin
                        next_state.status.prog_err = 1'b1;
                     end else begin
                        next_state.cmd.start_program = 1'b1;
                     end
                  end
               end
               sfs_pkg::OP_SECTOR_ERASE: begin
                  if (state.status.write_enable_latch) begin
                     next_state.status.busy_flag = 1'b1;
                     if (target_protected) begin
                        next_state.status.erase_err = 1'b1;
                     end else begin
                        next_state.cmd.start_sector_erase = 1'b1;
                     end
                  end
               end
               sfs_pkg::OP_WHOLE_ERASE: begin
                  // skipped protected sectors inside never raise an error
                  if (state.status.write_enable_latch && state.status.protect_bits == 3'h0) begin
                     next_state.status.busy_flag = 1'b1;
                     next_state.cmd.start_whole_erase = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // register data byte complete: the lock bit loads, protect bits load unless frozen, the latch clears
      // any other byte in the data phase is shifted in and dropped; the
      // opcode is emptied at once so later bytes of the same frame can
      // never write a second time; the error and busy bits are read-only
      // here and the latch only clears, whatever the host sends in their positions
      if (byte_done && state.phase == sfs_pkg::ST_DATA) begin
         next_state.bit_cnt = '0;
         next_state.opcode = '0;
         if (state.opcode == sfs_pkg::OP_WRITE_REGISTERS) begin
            next_state.status.status_write_lock = byte_val[sfs_pkg::BIT_LOCK];
            if (!frozen) begin
               next_state.status.protect_bits = byte_val[sfs_pkg::BIT_BP_HI:sfs_pkg::BIT_BP_LO];
            end
            next_state.status.write_enable_latch = 1'b0;
         end
      end
   end

   // reset loads defaults; protect bits come from storage unless volatile
   // the reset is synchronous, so reading the stored-value ports here is
   // safe; select sync starts high and the edge history low, matching
   // the idle levels of the pins so no false edge follows reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= '0;
         state.sel_sync <= 2'h3;
         state.clk_prev <= 1'b0;
         state.phase <= sfs_pkg::ST_IDLE;
         state.status.status_write_lock <= nv_status_write_lock;
         state.status.protect_bits <= config_register_one[sfs_pkg::CFG_PROTECT_VOLATILITY_BIT] ?
            sfs_pkg::BP_RESET_VOLATILE : nv_protect_bits;
      end else begin
         state <= next_state;
      end
   end

   // every output comes straight from a register of the state struct,
   // so the host sees no combinational path from the link pins; the
   // command strobes last exactly one core cycle
   assign serial_out = state.dout;
   assign serial_out_en = state.dout_en;
   assign cmd = state.cmd;
   assign flash_status_one = sfs_pack(state.status);
endmodule

// [tb/sfs_status_reg_asserts.sv]
`timescale 1ns/1ps
module sfs_status_reg_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic select_n,
   input wire logic write_protect_n,
   input wire logic [7:0] config_register_one,
   input wire logic [2:0] nv_protect_bits,
   input wire logic nv_status_write_lock,
   input wire sfs_pkg::sfs_engine_t engine,
   input wire logic serial_out_en,
   input wire sfs_pkg::sfs_cmd_t cmd,
   input wire logic [7:0] flash_status_one
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   reset_value_a: assert property ($past(rst) |-> flash_status_one == {$past(nv_status_write_lock),
      2'h0, ($past(config_register_one[3]) ? 3'h7 : $past(nv_protect_bits)), 2'h0}) else $error("bad reset value");
   latch_gate_a: assert property (cmd.start_program || cmd.start_sector_erase || cmd.start_whole_erase
      |-> $past(flash_status_one[1])) else $error("start without latch");
   busy_gate_a: assert property (cmd.start_program || cmd.start_sector_erase || cmd.start_whole_erase
      |-> !$past(flash_status_one[0])) else $error("start while busy");
   whole_erase_gate_a: assert property (cmd.start_whole_erase |-> flash_status_one[4:2] == 3'h0)
      else $error("whole erase with protection");
   error_busy_a: assert property (|flash_status_one[6:5] |-> flash_status_one[0])
      else $error("error without busy");
   erase_susp_a: assert property (cmd.erase_suspend |-> engine.erase_in_progress)
      else $error("erase suspend when idle");
   prog_susp_a: assert property (cmd.program_suspend |-> engine.prog_in_progress)
      else $error("program suspend when idle");
   latch_source_a: assert property ($rose(flash_status_one[1]) |-> !$past(select_n))
      else $error("latch set outside frame");
   error_clear_a: assert property ($fell(flash_status_one[6]) |-> !$past(select_n))
      else $error("error cleared outside frame");
   drive_release_a: assert property (select_n [*5] |-> !serial_out_en)
      else $error("driving while deselected");
endmodule
bind sfs_status_reg sfs_status_reg_asserts chk_i (.core_clk(core_clk), .rst(rst), .select_n(select_n),
   .write_protect_n(write_protect_n), .config_register_one(config_register_one),
   .nv_protect_bits(nv_protect_bits), .nv_status_write_lock(nv_status_write_lock), .engine(engine),
   .serial_out_en(serial_out_en), .cmd(cmd), .flash_status_one(flash_status_one));

// [tb/sfs_host.sv]
`timescale 1ns/1ps
// host end of the link; its clock stands low between frames
module sfs_host (
   input wire logic core_clk,
   input wire logic serial_out,
   output logic select_n,
   output logic serial_clk,
   output logic serial_in
);
   // idle levels from time zero: deselected, clock low
   initial begin
      select_n = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
   end
   // half a link period is 4 core cycles, 160 ns
   task automatic half();
      repeat (4) @(posedge core_clk);
   endtask
   // n bits of d msb first, then rd status bytes taken on rising link edges
   task automatic frame(input logic [15:0] d, input int n, input int rd, output logic [15:0] q);
      q = 16'h0000;
      select_n <= 1'b0;
      for (int i = 15; i >= 16 - n; i--) begin
         serial_in <= d[i];
         half();
         serial_clk <= 1'b1;
         half();
         serial_clk <= 1'b0;
      end
      for (int i = 0; i < 8 * rd; i++) begin
         serial_in <= ~serial_in;
         half();
         serial_clk <= 1'b1;
         q = {q[14:0], serial_out};
         half();
         serial_clk <= 1'b0;
      end
      half();
      select_n <= 1'b1;
      serial_in <= ~serial_in; // released line must not keep a stale value
      half();
   endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   typedef struct packed {logic [15:0] d; logic [4:0] n; logic wp; logic [7:0] st;} sfs_row_t;
   logic core_clk, rst, select_n, serial_clk, serial_in, write_protect_n, target_protected;
   logic [7:0] config_register_one;
   logic [2:0] nv_protect_bits;
   logic nv_status_write_lock, serial_out, serial_out_en;
   sfs_pkg::sfs_engine_t engine;
   sfs_pkg::sfs_cmd_t cmd;
   logic [7:0] flash_status_one;
   logic [15:0] q;
   logic [23:0] pc = 24'h000000;
   int n_mismatch = 0;
   int comparisons = 0;
   sfs_row_t rows [9] = '{'{16'h0600, 5'h08, 1'b1, 8'h02}, '{16'h0400, 5'h08, 1'b1, 8'h00},
      '{16'h0106, 5'h10, 1'b1, 8'h00}, '{16'h0600, 5'h08, 1'b1, 8'h02}, '{16'h01FF, 5'h10, 1'b1, 8'h9C},
      '{16'h0600, 5'h08, 1'b1, 8'h9E}, '{16'h0100, 5'h10, 1'b0, 8'h9E}, '{16'h0100, 5'h10, 1'b1, 8'h00},
      '{16'h6000, 5'h08, 1'b1, 8'h00}};
   sfs_status_reg uut (.core_clk(core_clk), .rst(rst), .select_n(select_n), .serial_clk(serial_clk),
      .serial_in(serial_in), .write_protect_n(write_protect_n), .config_register_one(config_register_one),
      .nv_protect_bits(nv_protect_bits), .nv_status_write_lock(nv_status_write_lock),
      .target_protected(target_protected), .engine(engine), .serial_out(serial_out),
      .serial_out_en(serial_out_en), .cmd(cmd), .flash_status_one(flash_status_one));
   sfs_host host (.core_clk(core_clk), .serial_out(serial_out), .select_n(select_n),
      .serial_clk(serial_clk), .serial_in(serial_in));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // one nibble per command strobe, program start in the top nibble
   always @(posedge core_clk) begin
      for (int i = 0; i < 6; i++) begin
         pc[4*i+:4] <= pc[4*i+:4] + {3'h0, cmd[i]};
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [15:0] d, input logic [4:0] n);
      host.frame(d, n, 0, q);
      repeat (2) @(posedge core_clk);
   endtask
   // engine pulse for one cycle, levels kept
   task automatic ev(input sfs_pkg::sfs_engine_t e);
      engine <= e;
      @(posedge core_clk);
      engine <= {3'h0, e[1:0]};
      @(posedge core_clk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      n_mismatch++;
      conclude();
   end
   initial begin
      rst <= 1'b1;
      write_protect_n <= 1'b1;
      target_protected <= 1'b0;
      config_register_one <= 8'h00;
      nv_protect_bits <= 3'h0;
      nv_status_write_lock <= 1'b0;
      engine <= 5'h00;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(flash_status_one, 8'h00);
      foreach (rows[i]) begin
         write_protect_n <= rows[i].wp;
         op(rows[i].d, rows[i].n);
         chk(flash_status_one, rows[i].st);
      end
      $display("table done");
      target_protected <= 1'b1;
      op(16'h0600, 5'h08);
      op(16'h0200, 5'h08);
      host.frame(16'h0500, 8, 2, q);
      chk(q, 16'h4343);
      op(16'h0400, 5'h08);
      chk(flash_status_one, 8'h43);
      op(16'h3000, 5'h08);
      op(16'h0400, 5'h08);
      chk(flash_status_one, 8'h00);
      target_protected <= 1'b0;
      op(16'h0600, 5'h08);
      op(16'hD800, 5'h08);
      engine <= 5'h01;
      op(16'h7500, 5'h08);
      op(16'h8500, 5'h08);
      ev(5'h05);
      ev(5'h10);
      chk(flash_status_one & 8'h61, 8'h21);
      op(16'h3000, 5'h08);
      op(16'h0400, 5'h08);
      chk(pc, 24'h010100);
      $display("error cases done");
      op(16'h0600, 5'h08);
      op(16'h0110, 5'h10);
      op(16'h0600, 5'h08);
      op(16'h6000, 5'h08);
      chk(flash_status_one, 8'h12);
      op(16'h0100, 5'h10);
      op(16'h0600, 5'h08);
      target_protected <= 1'b1;
      op(16'h6000, 5'h08);
      ev(5'h10);
      chk(flash_status_one, 8'h00);
      target_protected <= 1'b0;
      op(16'h0600, 5'h08);
      op(16'hD800, 5'h08);
      op(16'hF000, 5'h08);
      ev(5'h10);
      chk(pc, 24'h021101);
      $display("erase cases done");
      config_register_one <= 8'h08;
      nv_status_write_lock <= 1'b1;
      nv_protect_bits <= 3'h2;
      rst <= 1'b1;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(flash_status_one, 8'h9C);
      config_register_one <= 8'h09;
      op(16'h0600, 5'h08);
      op(16'h0100, 5'h10);
      chk(flash_status_one & 8'h1C, 8'h1C);
      $display("reset cases done");
      conclude();
   end
endmodule
